// ==== ccarr_pin_model.sv ====
// ccarr_pin_model: far-side pins of the counter array, capture inputs and count input
// assumes: drive() is called from the testbench between clock edges
`timescale 1ns/100ps
module ccarr_pin_model (
  // clock
  input  wire logic       sys_clk,
  // pins toward the array
  output logic [4:0]      pin_in,
  output logic            ext_cnt,
  input  wire logic [4:0] pin_out
);
  int         toggle_on_match [5] = '{default: 0};
  logic [4:0] last = 5'h00;

  // count input stays quiet: no source test uses it
  initial begin
    pin_in  = 5'h00;
    ext_cnt = 1'b0;
  end
  // ****
  // pin level changes land just after an edge
  // ****
  task automatic drive(input int m, input logic lvl);
    @(posedge sys_clk);
    pin_in[m] <= lvl;
  endtask : drive

  always @(posedge sys_clk) begin
    foreach (toggle_on_match[i]) if (pin_out[i] !== last[i]) toggle_on_match[i]++;
    last <= pin_out;
  end
endmodule : ccarr_pin_model

// ==== ccarr_pkg.sv ====
// ccarr_pkg: register map, field positions and shared types of the counter array
// assumes: AHB-Lite slave with 32-bit data, one aligned word per register
package ccarr_pkg;

  // ****************************************************************
  // register byte addresses
  // ****************************************************************
  localparam logic [7:0] CCARR_MODE_OFS  = 8'h00; // counter_mode_register
  localparam logic [7:0] CCARR_CTRL_OFS  = 8'h04; // counter_control_register
  localparam logic [7:0] CCARR_CNTL_OFS  = 8'h08; // counter_low_byte
  localparam logic [7:0] CCARR_CNTH_OFS  = 8'h0C; // counter_high_byte
  localparam logic [7:0] CCARR_MMC_BASE  = 8'h10; // module_mode_control n at base+4n
  localparam logic [7:0] CCARR_CMPL_BASE = 8'h30; // compare_low_byte n
  localparam logic [7:0] CCARR_CMPH_BASE = 8'h50; // compare_high_byte n
  localparam logic [7:0] CCARR_WDKICK    = 8'h70; // watchdog service offset, decoded by no register

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int MMC_IRQ_EN  = 0;
  localparam int MMC_PWM     = 1;
  localparam int MMC_TOG     = 2;
  localparam int MMC_MATCH   = 3;
  localparam int MMC_FALL    = 4;
  localparam int MMC_RISE    = 5;
  localparam int MMC_CMP_EN  = 6;
  localparam int MODE_OVF_IE = 0;
  localparam int MODE_SRC_LO = 1;
  localparam int MODE_SRC_HI = 2;
  localparam int MODE_WDT_EN = 6;
  localparam int MODE_IDLE   = 7;
  localparam int CTRL_RUN    = 6;
  localparam int CTRL_OVF    = 7;
  localparam int WDT_MODULE  = 4;

  localparam logic [7:0] MMC_RESET  = 8'h00;
  localparam logic [7:0] MODE_RMASK = 8'hC7;
  localparam logic [7:0] MMC_RMASK  = 8'h7F;

  // ****************************************************************
  // timing: source prescale counts in sys_clk cycles
  // ****************************************************************
  localparam logic [3:0] DIV_SLOW = 4'hB; // divide by 12, count 0..11
  localparam logic [3:0] DIV_FAST = 4'h3; // divide by 4
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {
    CCARR_SRC_DIV12 = 2'h0,
    CCARR_SRC_DIV4  = 2'h1,
    CCARR_SRC_T0OVF = 2'h2,
    CCARR_SRC_EXT   = 2'h3
  } ccarr_src_t;

  typedef struct packed {
    logic        sel;
    logic        write;
    logic [7:0]  addr;
  } ccarr_req_t;

endpackage : ccarr_pkg

// ==== ccarr_top.sv ====
// ccarr_top: counter array with five compare/capture modules behind AHB-Lite
// assumes: module pins and external count input are asynchronous, timer 0
// overflow and idle come from logic on sys_clk
//
// Implementation choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/100ps
module ccarr_top
  import ccarr_pkg::*;
#(
  parameter int NMOD = 5
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  input  wire logic              clk_en,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // system
  input  wire logic              cpu_idle,
  input  wire logic              timer0_ovf,
  input  wire logic              external_count_input,
  // module pins
  input  wire logic [NMOD-1:0]   module_io_pin_in,
  output logic [NMOD-1:0]        module_io_pin_out,
  output logic                   counter_array_irq,
  output logic                   watchdog_reset
);

  // ****************************************************************
  // bus slave
  // ****************************************************************
  ccarr_req_t req_q;
  logic [31:0] rdata_q;
  logic        irq_q, wdr_q;
  wire         bus_take = hsel && hready && (htrans == HTRANS_NONSEQ);
  wire         wr_act   = req_q.sel && req_q.write && clk_en;
  wire [7:0]   wr_byte  = hwdata[7:0];
  wire [7:0]   a        = req_q.addr;
  wire         wr_mode  = wr_act && (a == CCARR_MODE_OFS);
  wire         wr_ctrl  = wr_act && (a == CCARR_CTRL_OFS);
  wire         wr_cntl  = wr_act && (a == CCARR_CNTL_OFS);
  wire         wr_cnth  = wr_act && (a == CCARR_CNTH_OFS);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      req_q <= '0;
    end else if (clk_en) begin
      req_q <= '{sel: bus_take, write: hwrite, addr: haddr[7:0]};
    end
  end

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [NMOD-1:0] pin_s1_q, pin_s2_q, pin_s3_q;
  logic [2:0]      eci_q;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
      eci_q    <= '0;
    end else if (clk_en) begin
      pin_s1_q <= module_io_pin_in;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      eci_q    <= {eci_q[1:0], external_count_input};
    end
  end

  // ****************************************************************
  // shared counter and count source
  // ****************************************************************
  logic [7:0]  mode_q;
  logic        run_q, ovf_q;
  logic [15:0] cnt_q;
  logic [3:0]  pre_q;
  ccarr_src_t  src;
  assign src = ccarr_src_t'({mode_q[MODE_SRC_HI], mode_q[MODE_SRC_LO]});
  wire gated   = mode_q[MODE_IDLE] && cpu_idle;
  wire pre_end = (pre_q == ((src == CCARR_SRC_DIV12) ? DIV_SLOW : DIV_FAST));
  wire eci_rise = eci_q[1] && !eci_q[2];
  // external edges are only seen after two flops, so rates near sys_clk/8 still resolve
  wire tick = run_q && !gated && clk_en &&
              ((src == CCARR_SRC_T0OVF) ? timer0_ovf :
               (src == CCARR_SRC_EXT)   ? eci_rise   : pre_end);
  wire wrap = tick && (cnt_q == 16'hFFFF);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pre_q <= '0;
      cnt_q <= '0;
    end else if (clk_en) begin
      pre_q <= (pre_end || !run_q) ? 4'h0 : pre_q + 4'h1;
      if (wr_cntl) begin
        cnt_q[7:0] <= wr_byte;
      end else if (wr_cnth) begin
        cnt_q[15:8] <= wr_byte;
      end else if (tick) begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end

  // ****************************************************************
  // modules
  // ****************************************************************
  logic [7:0]  mmc_q  [NMOD];
  logic [15:0] cmp_q  [NMOD];
  logic [NMOD-1:0] flag_q, pin_q, ev;
  logic [NMOD-1:0] irq_src;

  for (genvar n = 0; n < NMOD; n++) begin : g_mod
    localparam logic [7:0] OFS = 8'(4 * n);
    wire wr_mmc  = wr_act && (a == CCARR_MMC_BASE + OFS);
    wire wr_cl   = wr_act && (a == CCARR_CMPL_BASE + OFS);
    wire wr_ch   = wr_act && (a == CCARR_CMPH_BASE + OFS);
    wire [7:0] m = mmc_q[n];
    wire edge_r  = pin_s2_q[n] && !pin_s3_q[n];
    wire edge_f  = !pin_s2_q[n] && pin_s3_q[n];
    wire cap     = (m[MMC_RISE] && edge_r) || (m[MMC_FALL] && edge_f);
    wire match   = m[MMC_CMP_EN] && tick && (cnt_q + 16'h0001 == cmp_q[n]);
    wire pwm_hi  = cnt_q[7:0] < cmp_q[n][15:8];
    wire is_wdt  = (n == WDT_MODULE) && mode_q[MODE_WDT_EN];
    assign ev[n] = cap || (match && m[MMC_MATCH]);
    assign irq_src[n] = flag_q[n] && m[MMC_IRQ_EN];

    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        mmc_q[n] <= MMC_RESET;
        cmp_q[n] <= '0;
        pin_q[n] <= 1'b0;
      end else if (clk_en) begin
        if (wr_mmc) begin
          mmc_q[n] <= wr_byte & MMC_RMASK;
        end else if (wr_cl) begin
          mmc_q[n][MMC_CMP_EN] <= 1'b0;
        end else if (wr_ch) begin
          mmc_q[n][MMC_CMP_EN] <= 1'b1;
        end
        if (wr_cl) cmp_q[n][7:0] <= wr_byte;
        if (wr_ch) cmp_q[n][15:8] <= wr_byte;
        if (cap) cmp_q[n] <= cnt_q;
        if (m[MMC_PWM] && m[MMC_CMP_EN]) begin
          pin_q[n] <= !pwm_hi;
        end else if (match && m[MMC_TOG]) begin
          pin_q[n] <= !pin_q[n];
        end
      end
    end

    if (n == WDT_MODULE) begin : g_wdt
      always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          wdr_q <= 1'b0;
        end else if (clk_en) begin
          wdr_q <= is_wdt && match;
        end
      end
    end
  end

  // ****************************************************************
  // control, mode and flags
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      mode_q <= '0;
      run_q  <= 1'b0;
      ovf_q  <= 1'b0;
      flag_q <= '0;
    end else if (clk_en) begin
      if (wr_mode) mode_q <= wr_byte & MODE_RMASK;
      if (wr_ctrl) run_q <= wr_byte[CTRL_RUN];
      // hardware set wins over a software clear in the same cycle
      ovf_q  <= wrap || (wr_ctrl ? wr_byte[CTRL_OVF] & ovf_q : ovf_q);
      flag_q <= ev | (wr_ctrl ? wr_byte[NMOD-1:0] & flag_q : flag_q);
    end
  end

  wire irq_d = (|irq_src) || (ovf_q && mode_q[MODE_OVF_IE]);

  // ****************************************************************
  // read path and registered outputs
  // ****************************************************************
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (haddr[7:0] == CCARR_MODE_OFS) rd_byte = mode_q;
    if (haddr[7:0] == CCARR_CTRL_OFS) rd_byte = {ovf_q, run_q, 1'b0, flag_q};
    if (haddr[7:0] == CCARR_CNTL_OFS) rd_byte = cnt_q[7:0];
    if (haddr[7:0] == CCARR_CNTH_OFS) rd_byte = cnt_q[15:8];
    for (int i = 0; i < NMOD; i++) begin
      if (haddr[7:0] == CCARR_MMC_BASE + 8'(4 * i)) rd_byte = mmc_q[i];
      if (haddr[7:0] == CCARR_CMPL_BASE + 8'(4 * i)) rd_byte = cmp_q[i][7:0];
      if (haddr[7:0] == CCARR_CMPH_BASE + 8'(4 * i)) rd_byte = cmp_q[i][15:8];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= '0;
      irq_q   <= 1'b0;
    end else if (clk_en) begin
      if (bus_take && !hwrite) rdata_q <= {24'h000000, rd_byte};
      irq_q <= irq_d;
    end
  end

  assign hrdata            = rdata_q;
  assign hreadyout         = 1'b1;
  assign hresp             = 1'b0;
  assign module_io_pin_out = pin_q;
  assign counter_array_irq = irq_q;
  assign watchdog_reset    = wdr_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // ****************************************************************
  // checks: register side effects
  // ****************************************************************
  AST_CL_CLEARS_EN: assert property (clk_en && req_q.sel && req_q.write &&
    req_q.addr == CCARR_CMPL_BASE + 8'h08 |=> !mmc_q[2][MMC_CMP_EN])
    else $error("compare low write left comparator on");
  AST_CH_SETS_EN: assert property (clk_en && req_q.sel && req_q.write &&
    req_q.addr == CCARR_CMPH_BASE + 8'h08 |=> mmc_q[2][MMC_CMP_EN])
    else $error("compare high write did not enable comparator");
  AST_COMPARATOR_ENABLE_RW: assert property (wr_act && a == CCARR_MMC_BASE + 8'h04
    |=> mmc_q[1] == ($past(hwdata[7:0]) & MMC_RMASK))
    else $error("module mode write not taken");
  AST_RUN_BIT: assert property (wr_ctrl |=> run_q == $past(hwdata[CTRL_RUN]))
    else $error("run bit not taken");

  // ****************************************************************
  // checks: shared counter
  // ****************************************************************
  // software writes to the counter win over a tick, so they are left out
  AST_SRC_DIV4: assert property (clk_en && run_q && !gated && src == CCARR_SRC_DIV4 &&
    pre_q == DIV_FAST && !wr_cntl && !wr_cnth |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("div 4 tick missing");
  AST_SRC_DIV12: assert property (clk_en && run_q && !gated && src == CCARR_SRC_DIV12 &&
    pre_q == DIV_SLOW && !wr_cntl && !wr_cnth |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("div 12 tick missing");
  AST_RUN_STOP: assert property (clk_en && !run_q && !wr_cntl && !wr_cnth
    |=> $stable(cnt_q))
    else $error("counter moved while stopped");
  AST_OVF_CLR: assert property (clk_en && wr_ctrl && !wr_byte[CTRL_OVF] && !wrap
    |=> !ovf_q)
    else $error("overflow flag not cleared");
  AST_IDLE_HOLD: assert property (mode_q[MODE_IDLE] && cpu_idle && !wr_cntl && !wr_cnth
    |=> $stable(cnt_q))
    else $error("counter moved in idle");
  AST_OVF_FLAG: assert property (wrap |=> ovf_q)
    else $error("overflow not flagged");
  AST_IRQ_OVF: assert property (clk_en && ovf_q && mode_q[MODE_OVF_IE] |=> irq_q)
    else $error("overflow irq missing");

  // ****************************************************************
  // checks: capture
  // ****************************************************************
  AST_CAP_LOAD: assert property (clk_en && mmc_q[0][MMC_RISE] && pin_s2_q[0] && !pin_s3_q[0]
    |=> cmp_q[0] == $past(cnt_q))
    else $error("capture value wrong");
  AST_CAP_FALL: assert property (clk_en && mmc_q[2][MMC_FALL] && !pin_s2_q[2] && pin_s3_q[2]
    |=> cmp_q[2] == $past(cnt_q))
    else $error("falling capture value wrong");
  AST_NO_RISE2: assert property (clk_en && !mmc_q[2][MMC_RISE] && pin_s2_q[2] &&
    !pin_s3_q[2] && !wr_act |=> $stable(cmp_q[2]))
    else $error("capture on disabled edge");
  AST_CAP_FLAG: assert property (clk_en && ev[2] |=> flag_q[2])
    else $error("event flag not set");
  AST_IRQ_MOD: assert property (clk_en && flag_q[0] && mmc_q[0][MMC_IRQ_EN] |=> irq_q)
    else $error("module irq missing");
  AST_IRQ_OFF: assert property (clk_en && !(|irq_src) && !(ovf_q && mode_q[MODE_OVF_IE])
    |=> !irq_q)
    else $error("irq without enabled source");
  AST_FLAG_CLR: assert property (clk_en && wr_ctrl && !wr_byte[1] && !ev[1]
    |=> !flag_q[1])
    else $error("module flag not cleared");
  AST_NO_CAP: assert property (clk_en && mmc_q[0][5:4] == 2'b00 && !wr_act
    |=> $stable(cmp_q[0]))
    else $error("capture without edge enable");

  // ****************************************************************
  // checks: compare, pwm and watchdog
  // ****************************************************************
  // pwm owns the pin, so toggling is only checked outside pwm
  AST_HSO_TOGGLE: assert property (tick && mmc_q[1][MMC_CMP_EN] && mmc_q[1][MMC_TOG] &&
    !mmc_q[1][MMC_PWM] && (cnt_q + 16'h0001 == cmp_q[1])
    |=> pin_q[1] != $past(pin_q[1]))
    else $error("fast output did not toggle");
  AST_MATCH_FLAG: assert property (tick && mmc_q[1][MMC_CMP_EN] && mmc_q[1][MMC_MATCH] &&
    (cnt_q + 16'h0001 == cmp_q[1]) |=> flag_q[1])
    else $error("match flag missing");
  AST_PWM_LEVEL: assert property (clk_en && mmc_q[3][MMC_PWM] && mmc_q[3][MMC_CMP_EN]
    |=> pin_q[3] == ($past(cnt_q[7:0]) >= $past(cmp_q[3][15:8])))
    else $error("pwm level wrong");
  AST_WDT_PULSE: assert property (tick && mode_q[MODE_WDT_EN] && mmc_q[4][MMC_CMP_EN] &&
    (cnt_q + 16'h0001 == cmp_q[4]) |=> wdr_q)
    else $error("watchdog pulse missing");
  AST_NO_WDT: assert property (clk_en && !mode_q[MODE_WDT_EN] |=> !wdr_q)
    else $error("watchdog pulse while disabled");

  // ****************************************************************
  // cover
  // ****************************************************************
  COV_CAPTURE: cover property (ev[0] && mmc_q[0][MMC_RISE]);
  COV_TOGGLE: cover property (pin_q[1] ##[1:300] !pin_q[1]);
  COV_WRAP: cover property (wrap);
  COV_WDT: cover property (wdr_q);
  COV_OVF_IRQ: cover property (ovf_q && irq_q);

endmodule : ccarr_top

// ==== ccarr_top_tb.sv ====
// ccarr_top_tb: register-level tests of the counter array over ahb-lite
// assumes: ccarr_pkg, ccarr_top and ccarr_pin_model are compiled first
`timescale 1ns/100ps
module ccarr_top_tb;
  import ccarr_pkg::*;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        cpu_idle = 1'b0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        counter_array_irq;
  logic        watchdog_reset;
  logic [4:0]  pin_in;
  logic [4:0]  pin_out;
  logic        ext_cnt;
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          base;
  logic [7:0]  r;
  logic        seen;
  int          counter_mode_register [3] = '{0, 2, 4};
  logic [7:0]  cset [3] = '{8'h21, 8'h10, 8'h30};

  always #20 sys_clk = ~sys_clk;

  ccarr_top #(.NMOD(5)) i_dut (.sys_clk(sys_clk), .nrst(nrst), .clk_en(1'b1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(), .cpu_idle(cpu_idle), .timer0_ovf(1'b0), .external_count_input(ext_cnt),
    .module_io_pin_in(pin_in), .module_io_pin_out(pin_out),
    .counter_array_irq(counter_array_irq), .watchdog_reset(watchdog_reset));

  ccarr_pin_model i_pins (.sys_clk(sys_clk), .pin_in(pin_in), .ext_cnt(ext_cnt),
    .pin_out(pin_out));

  // ****
  // bus and compare tasks
  // ****
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out

  task automatic chk_in(input logic [7:0] v, lo, hi, input string what);
    cmp_count++;
    if (!(v >= lo && v <= hi)) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h", $time, what, v);
    end
  endtask : chk_in

  task automatic chk(input logic [7:0] v, exp, input string what);
    cmp_count++;
    if (v !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, v, exp);
    end
  endtask : chk

  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    q = hrdata[7:0];
  endtask : bus

  task automatic wr(input logic [7:0] a, d);
    logic [7:0] q;
    bus(a, 1'b1, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    bus(a, 1'b0, 8'h00, q);
  endtask : rd

  // counter advance over 403 clocks, low byte only, wrap-safe
  task automatic rate(input logic [7:0] lo, hi);
    logic [7:0] a, b;
    rd(CCARR_CNTL_OFS, a);
    repeat (400) @(posedge sys_clk);
    rd(CCARR_CNTL_OFS, b);
    chk_in(b - a, lo, hi, "count rate");
  endtask : rate

  task automatic cap_edge(input int m, input logic lvl, hit);
    logic [7:0] prev, a, b, v;
    rd(CCARR_CMPL_BASE + 8'(4 * m), prev);
    rd(CCARR_CNTL_OFS, a);
    i_pins.drive(m, lvl);
    repeat (6) @(posedge sys_clk);
    rd(CCARR_CNTL_OFS, b);
    rd(CCARR_CMPL_BASE + 8'(4 * m), v);
    if (hit) chk_in(v - a, 8'h00, b - a, "captured");
    else chk(v, prev, "no capture");
  endtask : cap_edge

  // index 5 watches the watchdog pulse
  task automatic wait_for(input int w, output logic s);
    s = 1'b0;
    for (int i = 0; i < 2200 && s !== 1'b1; i++) begin
      @(posedge sys_clk);
      s = (w == 5) ? watchdog_reset : pin_out[w];
    end
  endtask : wait_for

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end
  // ****
  // tests
  // ****
  initial begin
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(CCARR_MODE_OFS, r);
    chk(r, 8'h00, "mode reset");
    rd(CCARR_MMC_BASE, r);
    chk(r, MMC_RESET, "mmc reset");
    wr(CCARR_CMPH_BASE + 8'h08, 8'h12);
    rd(CCARR_MMC_BASE + 8'h08, r);
    chk(r, 8'h40, "high write");
    wr(CCARR_CMPL_BASE + 8'h08, 8'h34);
    rd(CCARR_MMC_BASE + 8'h08, r);
    chk(r, 8'h00, "low write");
    wr(CCARR_MMC_BASE + 8'h08, 8'h7F);
    rd(CCARR_MMC_BASE + 8'h08, r);
    chk(r, 8'h7F, "mmc readback");
    wr(CCARR_MMC_BASE + 8'h08, 8'h00);
    wr(CCARR_MODE_OFS, 8'h02);
    wr(CCARR_CTRL_OFS, 8'h40);
    cpu_idle <= 1'b1;
    rate(8'd98, 8'd103);
    wr(CCARR_MODE_OFS, 8'h82);
    rate(8'd0, 8'd0);
    cpu_idle <= 1'b0;
    wr(CCARR_MODE_OFS, 8'h00);
    rate(8'd32, 8'd35);
    wr(CCARR_MODE_OFS, 8'h02);
    rd(CCARR_CNTH_OFS, r);
    wr(CCARR_CMPL_BASE + 8'h04, 8'h00);
    wr(CCARR_CMPH_BASE + 8'h04, r + 8'h02);
    wr(CCARR_MMC_BASE + 8'h04, 8'h4D);
    wait_for(1, seen);
    chk(8'(seen), 8'h01, "output toggle");
    rd(CCARR_CTRL_OFS, r);
    chk(r, 8'h42, "match flag");
    chk(8'(counter_array_irq), 8'h01, "match irq");
    wr(CCARR_CTRL_OFS, 8'h40);
    wr(CCARR_CMPL_BASE + 8'h0C, 8'h00);
    wr(CCARR_CMPH_BASE + 8'h0C, 8'h80);
    wr(CCARR_MMC_BASE + 8'h0C, 8'h42);
    base = i_pins.toggle_on_match[3];
    repeat (1100) @(posedge sys_clk);
    chk_in(8'(i_pins.toggle_on_match[3] - base), 8'd2, 8'd4, "pwm edges");
    foreach (counter_mode_register[i]) begin
      wr(CCARR_MMC_BASE + 8'(4 * counter_mode_register[i]), cset[i]);
      cap_edge(counter_mode_register[i], 1'b1, cset[i][MMC_RISE]);
      cap_edge(counter_mode_register[i], 1'b0, cset[i][MMC_FALL]);
    end
    rd(CCARR_CTRL_OFS, r);
    chk(r, 8'h55, "capture flags");
    chk(8'(counter_array_irq), 8'h01, "capture irq");
    rd(CCARR_CNTH_OFS, r);
    wr(CCARR_CMPL_BASE + 8'h10, 8'h00);
    wr(CCARR_CMPH_BASE + 8'h10, r + 8'h02);
    wr(CCARR_MMC_BASE + 8'h10, 8'h48);
    wr(CCARR_MODE_OFS, 8'h42);
    wait_for(5, seen);
    chk(8'(seen), 8'h01, "watchdog pulse");
    wr(CCARR_CTRL_OFS, 8'h40);
    wr(CCARR_MODE_OFS, 8'h03);
    wr(CCARR_CNTL_OFS, 8'hF0);
    wr(CCARR_CNTH_OFS, 8'hFF);
    repeat (200) @(posedge sys_clk);
    rd(CCARR_CTRL_OFS, r);
    chk(r, 8'hC0, "overflow flag");
    chk(8'(counter_array_irq), 8'h01, "overflow irq");
    close_out();
  end
endmodule : ccarr_top_tb
